//--- core/tmc_pkg.sv
package tmc_pkg;

	// control/status register numbers of the compare words
	localparam logic [11:0] TMC_ADDR_SUP_CMP    = 12'h14D;
	localparam logic [11:0] TMC_ADDR_SUP_CMPH   = 12'h15D;
	localparam logic [11:0] TMC_ADDR_GUEST_CMP  = 12'h24D;
	localparam logic [11:0] TMC_ADDR_GUEST_CMPH = 12'h25D;

	// all ones so nothing is pending out of reset
	localparam logic [63:0] TMC_CMP_RESET = 64'hFFFF_FFFF_FFFF_FFFF;

	// compare feature enable in both environment configuration words
	localparam int TMC_SUP_COMPARE_FEATURE_ENABLE_BIT = 63;
	localparam int TMC_HALF_LSB = 32;

	// privilege encoding of the hart, in order of rank
	typedef enum logic [1:0] {
		TMC_PRIV_U,
		TMC_PRIV_S,
		TMC_PRIV_RSVD,
		TMC_PRIV_M
	} tmc_priv_t;

	// merge a write into a 64-bit compare word, whole or one half
	function automatic logic [63:0] tmc_merge(
		input logic [63:0] old,
		input logic [63:0] wdata,
		input logic        hi,
		input logic        full
	);
		logic [63:0] res;
		res = old;
		if (full)
			res = wdata;
		else if (hi)
			res[63:TMC_HALF_LSB] = wdata[31:0];
		else
			res[31:0] = wdata[31:0];
		return res;
	endfunction

endpackage

//--- core/tmc_cmp_if.sv
`timescale 1ns/100ps
interface tmc_cmp_if #(parameter int W = 64);
	logic [W-1:0] value;
	logic [W-1:0] limit;
	logic         pending;

	modport unit (input value, input limit, output pending);
	modport user (output value, output limit, input pending);
endinterface

//--- core/tmc_cmp.sv
`timescale 1ns/100ps
module tmc_cmp
	import tmc_pkg::*;
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rstn_in,
	// compare pair
	tmc_cmp_if.unit   cmp
);

	logic reached;

	assign reached = cmp.value >= cmp.limit;

	// fresh every cycle, no hold beyond the compare itself
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			cmp.pending <= 1'b0;
		else
			cmp.pending <= reached;
	end

endmodule // tmc_cmp

//--- core/tmc_timer_compare.sv
`timescale 1ns/100ps
module tmc_timer_compare
	import tmc_pkg::*;
#(
	parameter int XLEN = 64
)
(
	// clock and reset
	input  wire logic            clk_in,
	input  wire logic            rstn_in,
	// csr access port
	input  wire logic            csr_req_in,
	input  wire logic            csr_we_in,
	input  wire logic [11:0]     csr_addr_in,
	input  wire logic [XLEN-1:0] csr_wdata_in,
	input  wire logic [1:0]      priv_in,
	input  wire logic            virt_in,
	// access and feature controls
	input  wire logic            mcounteren_tm_in,
	input  wire logic            hcounteren_tm_in,
	input  wire logic [63:0]     menvcfg_in,
	input  wire logic [63:0]     henvcfg_in,
	// time base and injected pending
	input  wire logic [63:0]     time_in,
	input  wire logic [63:0]     time_delta_in,
	input  wire logic            hvip_guest_pending_in,
	input  wire logic            mip_sup_timer_pending_we_in,
	input  wire logic            mip_sup_timer_pending_wdata_in,
	// csr answer
	output logic                 csr_ack_out,
	output logic                 csr_hit_out,
	output logic [XLEN-1:0]      csr_rdata_out,
	output logic                 csr_illegal_out,
	output logic                 csr_virtual_out,
	// pending flags
	output logic                 sup_timer_pending_out,
	output logic                 guest_timer_pending_out,
	output logic                 guest_timer_active_out
);

	localparam logic IS_RV32 = (XLEN == 32);

	tmc_cmp_if #(.W(64)) sup_if ();
	tmc_cmp_if #(.W(64)) guest_if ();

	logic [63:0] sup_cmp;
	logic [63:0] guest_cmp;
	logic        sw_sup_timer_pending;

	wire         addr_s;
	wire         addr_sh;
	wire         addr_g;
	wire         addr_gh;
	wire         hit;
	wire         is_m;
	wire         is_u;
	wire         sup_compare_feature_enable_m;
	wire         sup_compare_feature_enable_h;
	wire         tm_block;
	wire         guest_csr;
	wire         illegal;
	wire         virt_trap;
	wire         ok;
	wire         redirect;
	wire         tgt_guest;
	wire         hi;
	wire         full;
	wire         wr_s;
	wire         wr_g;
	wire [63:0]  wdata64;
	wire [63:0]  rd_word;
	wire [XLEN-1:0] rd_val;
	wire [63:0]  guest_time;
	wire [63:0]  next_sup_cmp;
	wire [63:0]  next_guest_cmp;
	wire         next_sw_sup_timer_pending;
	wire         next_sup_timer_pending;
	wire         next_guest;

	// high halves exist only on 32-bit harts
	assign addr_s    = csr_addr_in == TMC_ADDR_SUP_CMP;
	assign addr_sh   = IS_RV32 && csr_addr_in == TMC_ADDR_SUP_CMPH;
	assign addr_g    = csr_addr_in == TMC_ADDR_GUEST_CMP;
	assign addr_gh   = IS_RV32 && csr_addr_in == TMC_ADDR_GUEST_CMPH;
	assign hit       = csr_req_in && (addr_s || addr_sh || addr_g || addr_gh);
	assign guest_csr = addr_g || addr_gh;

	assign is_m   = priv_in == TMC_PRIV_M;
	assign is_u   = priv_in == TMC_PRIV_U;
	// hypervisor enable reads as zero while the machine enable is clear
	assign sup_compare_feature_enable_m = menvcfg_in[TMC_SUP_COMPARE_FEATURE_ENABLE_BIT];
	assign sup_compare_feature_enable_h = sup_compare_feature_enable_m && henvcfg_in[TMC_SUP_COMPARE_FEATURE_ENABLE_BIT];

	// lower modes need both the timer access bit and the feature enable
	assign tm_block  = !is_m && (!mcounteren_tm_in || !sup_compare_feature_enable_m);
	assign illegal   = hit && (tm_block || (is_u && !virt_in));
	// guest side: direct guest numbers, user mode or blocked redirect
	assign virt_trap = hit && !illegal && virt_in && !is_m
		&& (is_u || guest_csr || !hcounteren_tm_in || !sup_compare_feature_enable_h);
	assign ok        = hit && !illegal && !virt_trap;
	assign redirect  = virt_in && !is_m;
	assign tgt_guest = guest_csr || redirect;
	assign hi        = addr_sh || addr_gh;
	assign full      = !IS_RV32;

	assign wdata64 = 64'(csr_wdata_in);
	assign wr_s    = ok && csr_we_in && !tgt_guest;
	assign wr_g    = ok && csr_we_in && tgt_guest;

	assign next_sup_cmp = wr_s
		? tmc_merge(sup_cmp, wdata64, hi, full) : sup_cmp;
	assign next_guest_cmp = wr_g
		? tmc_merge(guest_cmp, wdata64, hi, full) : guest_cmp;

	assign rd_word = tgt_guest ? guest_cmp : sup_cmp;
	assign rd_val  = hi ? XLEN'(rd_word[63:TMC_HALF_LSB])
		: XLEN'(rd_word);

	// offset sum wraps at 64 bits by width
	assign guest_time = time_in + time_delta_in;

	assign sup_if.value   = time_in;
	assign sup_if.limit   = sup_cmp;
	assign guest_if.value = guest_time;
	assign guest_if.limit = guest_cmp;

	// machine software owns the bit only while the feature is off
	assign next_sw_sup_timer_pending = (mip_sup_timer_pending_we_in && !sup_compare_feature_enable_m)
		? mip_sup_timer_pending_wdata_in : sw_sup_timer_pending;
	assign next_sup_timer_pending  = sup_compare_feature_enable_m ? sup_if.pending : sw_sup_timer_pending;
	assign next_guest = hvip_guest_pending_in
		|| (sup_compare_feature_enable_h && guest_if.pending);

	tmc_cmp u_sup_cmp (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.cmp     (sup_if)
	);

	tmc_cmp u_guest_cmp (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.cmp     (guest_if)
	);

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			sup_cmp   <= TMC_CMP_RESET;
			guest_cmp <= TMC_CMP_RESET;
			sw_sup_timer_pending   <= 1'b0;
		end
		else
		begin
			sup_cmp   <= next_sup_cmp;
			guest_cmp <= next_guest_cmp;
			sw_sup_timer_pending   <= next_sw_sup_timer_pending;
		end
	end

	// answer one cycle after the request; trapped reads return zero
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			csr_ack_out     <= 1'b0;
			csr_hit_out     <= 1'b0;
			csr_rdata_out   <= '0;
			csr_illegal_out <= 1'b0;
			csr_virtual_out <= 1'b0;
		end
		else
		begin
			csr_ack_out     <= csr_req_in;
			csr_hit_out     <= hit;
			csr_rdata_out   <= ok ? rd_val : '0;
			csr_illegal_out <= illegal;
			csr_virtual_out <= virt_trap;
		end
	end

	// no enable of our own; the core applies enables and delegation
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			sup_timer_pending_out   <= 1'b0;
			guest_timer_pending_out <= 1'b0;
			guest_timer_active_out  <= 1'b0;
		end
		else
		begin
			sup_timer_pending_out   <= next_sup_timer_pending;
			guest_timer_pending_out <= next_guest;
			guest_timer_active_out  <= next_guest && virt_in;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	sequence sup_reached;
		sup_compare_feature_enable_m && (time_in >= sup_cmp) ##1 sup_compare_feature_enable_m;
	endsequence

	sequence sup_short;
		sup_compare_feature_enable_m && (time_in < sup_cmp) ##1 sup_compare_feature_enable_m;
	endsequence

	sequence guest_reached;
		sup_compare_feature_enable_h && (guest_time >= guest_cmp) ##1 sup_compare_feature_enable_h;
	endsequence

	sequence guest_short;
		sup_compare_feature_enable_h && (guest_time < guest_cmp)
		##1 (sup_compare_feature_enable_h && !hvip_guest_pending_in);
	endsequence

	chk_sup_pend_set: assert property (
		sup_reached |=> sup_timer_pending_out)
		else $error("supervisor pending missed a reached compare");

	chk_sup_pend_clear: assert property (
		sup_short |=> !sup_timer_pending_out)
		else $error("supervisor pending held past a larger compare");

	chk_guest_pend_set: assert property (
		guest_reached |=> guest_timer_pending_out)
		else $error("guest pending missed a reached compare");

	chk_guest_inject_or: assert property (
		hvip_guest_pending_in |=> guest_timer_pending_out)
		else $error("injected guest pending not reflected");

	chk_sw_sup_timer_pending_write: assert property (
		(!sup_compare_feature_enable_m && mip_sup_timer_pending_we_in && mip_sup_timer_pending_wdata_in)
		##1 (!sup_compare_feature_enable_m && !mip_sup_timer_pending_we_in) |=> sup_timer_pending_out)
		else $error("machine write of supervisor pending lost");

	chk_sw_sup_timer_pending_ignored: assert property (
		(sup_compare_feature_enable_m && mip_sup_timer_pending_we_in) |=> $stable(sw_sup_timer_pending))
		else $error("supervisor pending writable with compare on");

	chk_tm_illegal: assert property (
		(hit && !is_m && !mcounteren_tm_in) |=> csr_illegal_out)
		else $error("lower mode access without timer bit not trapped");

	chk_vs_redirect: assert property (
		(hit && csr_we_in && addr_s && virt_in && priv_in == TMC_PRIV_S
		&& mcounteren_tm_in && hcounteren_tm_in && sup_compare_feature_enable_h)
		|=> $stable(sup_cmp) && !csr_virtual_out && !csr_illegal_out)
		else $error("guest write not redirected to guest compare");

	chk_full_write: assert property (
		(!IS_RV32 && ok && csr_we_in && !tgt_guest)
		|=> sup_cmp == $past(wdata64))
		else $error("full compare write not stored");

	chk_active_virt: assert property (
		guest_timer_active_out |-> $past(virt_in))
		else $error("guest timer active outside virtualized mode");

	chk_guest_pend_clear: assert property (
		guest_short |=> !guest_timer_pending_out)
		else $error("guest pending held past a larger compare");

	chk_vs_blocked: assert property (
		(hit && virt_in && priv_in == TMC_PRIV_S && mcounteren_tm_in
		&& sup_compare_feature_enable_m && !hcounteren_tm_in) |=> csr_virtual_out)
		else $error("blocked guest access not sent to virtual trap");

	chk_refused_keep: assert property (
		(hit && csr_we_in && !is_m && !mcounteren_tm_in)
		|=> $stable(sup_cmp) && $stable(guest_cmp))
		else $error("refused compare write changed a register");

	chk_own_number: assert property (
		(csr_req_in && (csr_addr_in == TMC_ADDR_SUP_CMP
		|| csr_addr_in == TMC_ADDR_GUEST_CMP))
		|=> csr_ack_out && csr_hit_out)
		else $error("own compare number not answered as a hit");

	chk_guest_off: assert property (
		(!sup_compare_feature_enable_m && !hvip_guest_pending_in)
		|=> !guest_timer_pending_out)
		else $error("guest pending from compare with feature off");

endmodule // tmc_timer_compare

//--- verification/tmc_time_model.sv
`timescale 1ns/100ps
module tmc_time_model
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	// load and run control
	input  wire logic        load_in,
	input  wire logic [63:0] load_val_in,
	input  wire logic        run_in,
	// shared time
	output logic      [63:0] time_out
);
	// frozen unless loaded or run, so compare edges can be hit exactly
	always_ff @(posedge clk_in)
		if (!rstn_in)
			time_out <= 64'h0;
		else if (load_in)
			time_out <= load_val_in;
		else if (run_in)
			time_out <= time_out + 64'h1;
endmodule // tmc_time_model

//--- verification/tb_tmc_timer_compare.sv
`timescale 1ns/100ps
module tb_tmc_timer_compare
	import tmc_pkg::*;
	;
	logic        clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic        req, we, virt, mtm, htm, hvip, swe, swd, tload, trun;
	logic        ack, hit, ill, vir, sp, gp, ga;
	logic [1:0]  priv;
	logic [11:0] addr;
	logic [63:0] wdata, menv, henv, delta, tval, tnow, rd, c, g;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          i;

	always #2 clk_in = ~clk_in;

	tmc_timer_compare i_tmc_timer_compare (
		.clk_in(clk_in), .rstn_in(rstn_in), .csr_req_in(req),
		.csr_we_in(we), .csr_addr_in(addr), .csr_wdata_in(wdata),
		.priv_in(priv), .virt_in(virt), .mcounteren_tm_in(mtm),
		.hcounteren_tm_in(htm), .menvcfg_in(menv), .henvcfg_in(henv),
		.time_in(tnow), .time_delta_in(delta),
		.hvip_guest_pending_in(hvip), .mip_sup_timer_pending_we_in(swe),
		.mip_sup_timer_pending_wdata_in(swd), .csr_ack_out(ack), .csr_hit_out(hit),
		.csr_rdata_out(rd), .csr_illegal_out(ill),
		.csr_virtual_out(vir), .sup_timer_pending_out(sp),
		.guest_timer_pending_out(gp), .guest_timer_active_out(ga));

	tmc_time_model i_tmc_time_model (
		.clk_in(clk_in), .rstn_in(rstn_in), .load_in(tload),
		.load_val_in(tval), .run_in(trun), .time_out(tnow));

	function automatic logic pend(input logic [63:0] t, d, k);
		return (t + d) >= k;
	endfunction

	// expected {illegal, virtual} for the current mode and controls
	function automatic logic [1:0] refuse(input logic [11:0] a);
		if (priv == 2'h3)
			return 2'h0;
		if (!mtm || !menv[63] || (priv == 2'h0 && !virt))
			return 2'h2;
		if (virt && (priv == 2'h0 || a == TMC_ADDR_GUEST_CMP || !htm
			|| !henv[63]))
			return 2'h1;
		return 2'h0;
	endfunction

	function automatic logic [63:0] granted(input logic [11:0] a);
		return (a == TMC_ADDR_GUEST_CMP || (virt && priv != 2'h3))
			? g : tnow + 64'h1;
	endfunction

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// answer stands one cycle, sampled at the negedge it is up
	task automatic access(input logic w, input logic [11:0] a,
		input logic [63:0] d);
		@(negedge clk_in);
		req = 1'b1;
		we = w;
		addr = a;
		wdata = d;
		@(negedge clk_in);
		req = 1'b0;
		check("ack", ack, 64'h1);
	endtask

	task automatic settime(input logic [63:0] v);
		@(negedge clk_in);
		tload = 1'b1;
		tval = v;
		@(negedge clk_in);
		tload = 1'b0;
	endtask

	task automatic settle();
		repeat (4) @(negedge clk_in);
	endtask

	initial
	begin
		#40000;
		n_mismatch++;
		report_and_stop();
	end

	initial
	begin
		{req, we, virt, hvip, swe, swd, tload, trun} = 8'h0;
		{mtm, htm} = 2'h3;
		priv = 2'h3;
		addr = 12'h0;
		{wdata, delta, tval} = {3{64'h0}};
		menv = 64'h8000_0000_0000_0000;
		henv = menv;
		c = 64'($urandom(52024));
		repeat (16) @(negedge clk_in);
		rstn_in = 1'b1;
		settle();
		check("sp reset", sp, 64'h0);
		access(1'b0, TMC_ADDR_SUP_CMP, 64'h0);
		check("rd reset", rd, TMC_CMP_RESET);
		check("hit", hit, 64'h1);
		for (i = 0; i < 6; i++)
		begin
			c = {$urandom, $urandom};
			delta = {$urandom, $urandom};
			virt = i[0];
			settime(c + 64'(i % 3) - 64'h1);
			g = tnow + delta + 64'h1 - 64'(i % 3);
			access(1'b1, TMC_ADDR_SUP_CMP, c);
			access(1'b1, TMC_ADDR_GUEST_CMP, g);
			settle();
			check("sp", sp, pend(tnow, 64'h0, c));
			check("gp", gp, pend(tnow, delta, g));
			check("ga", ga, pend(tnow, delta, g) & virt);
			access(1'b0, TMC_ADDR_SUP_CMP, 64'h0);
			check("rd sup", rd, c);
			access(1'b0, TMC_ADDR_GUEST_CMP, 64'h0);
			check("rd guest", rd, g);
			access(1'b1, TMC_ADDR_SUP_CMP, tnow + 64'h1);
			settle();
			check("sp clear", sp, 64'h0);
		end
		for (i = 0; i < 24; i++)
		begin
			priv = 2'($urandom % 3);
			priv = (priv == 2'h2) ? 2'h3 : priv;
			{virt, mtm, htm, menv[63], henv[63]} = 5'($urandom);
			addr = i[0] ? TMC_ADDR_GUEST_CMP : TMC_ADDR_SUP_CMP;
			access(1'b0, addr, 64'h0);
			check("refuse", {ill, vir}, refuse(addr));
			if (refuse(addr) != 2'h0)
				check("rd refused", rd, 64'h0);
			else
				check("rd granted", rd, granted(addr));
		end
		{virt, priv, mtm, menv[63]} = {1'b0, 2'h1, 1'b0, 1'b1};
		access(1'b1, TMC_ADDR_SUP_CMP, 64'h0);
		priv = 2'h3;
		access(1'b0, TMC_ADDR_SUP_CMP, 64'h0);
		check("no write", rd, tnow + 64'h1);
		access(1'b0, TMC_ADDR_SUP_CMPH, 64'h0);
		check("hit high", hit, 64'h0);
		access(1'b0, 12'h14C, 64'h0);
		check("hit other", hit, 64'h0);
		{swe, swd} = 2'h3;
		settle();
		{swe, menv[63]} = 2'h0;
		settle();
		check("sw ignored", sp, 64'h0);
		swe = 1'b1;
		@(negedge clk_in);
		swe = 1'b0;
		settle();
		check("sw set", sp, 64'h1);
		{swe, swd} = 2'h2;
		settle();
		check("sw clear", sp, 64'h0);
		{swe, menv[63], henv[63]} = 3'h3;
		hvip = 1'b1;
		access(1'b1, TMC_ADDR_GUEST_CMP, 64'hFFFF_FFFF_FFFF_FFFF);
		settle();
		check("hvip", gp, 64'h1);
		hvip = 1'b0;
		trun = 1'b1;
		access(1'b1, TMC_ADDR_SUP_CMP, tnow + 64'h28);
		settle();
		check("sp early", sp, 64'h0);
		check("gp off", gp, 64'h0);
		repeat (50) @(negedge clk_in);
		check("sp late", sp, 64'h1);
		report_and_stop();
	end
endmodule // tb_tmc_timer_compare
